// file: logic/lsr_params.svh
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH
`define LSR_OFS_LOW_LIMIT_LO 5'h03
`define LSR_OFS_LOW_LIMIT_HI 5'h04
`define LSR_OFS_HIGH_LIMIT_LO 5'h05
`define LSR_OFS_HIGH_LIMIT_HI 5'h06
`define LSR_OFS_ANALOG_GAIN 5'h07
`define LSR_OFS_PART_REV_ID 5'h12
`define LSR_OFS_BROADBAND_LO 5'h14
`define LSR_OFS_BROADBAND_HI 5'h15
`define LSR_OFS_INFRARED_LO 5'h16
`define LSR_OFS_INFRARED_HI 5'h17
`define LSR_OFS_DURATION_LO 5'h18
`define LSR_OFS_DURATION_HI 5'h19
`define LSR_OFS_SUPP_IDENT 5'h1E
`define LSR_RESET_BYTE 8'h00
`define LSR_GAIN_LSB 0
`define LSR_GAIN_MSB 1
`define LSR_PART_NUMBER_CODE_LSB 4
`define LSR_SUPP_ID_BIT 7
`define LSR_SPF_IRQ_CLEAR 5'h01
`define LSR_SPF_STOP_MANUAL 5'h02
`define LSR_SPF_START_MANUAL 5'h03
`define LSR_TICK_NS 10900
`define LSR_CLK_PERIOD_PS 25000
`define LSR_CLK_MHZ 40
// 10.9 us at 40 MHz: 436 cycles per tick
`define LSR_TICK_CYCLES ((`LSR_TICK_NS * `LSR_CLK_MHZ) / 1000)
`define LSR_MAX_MANUAL_US 714300
`endif

// file: logic/lsr_pkg.sv
package lsr_pkg;
    typedef enum logic [1:0] {
        LSR_GAIN_1X = 2'b00,
        LSR_GAIN_8X = 2'b01,
        LSR_GAIN_16X = 2'b10,
        LSR_GAIN_111X = 2'b11
    } lsr_gain_e;
    typedef enum logic [1:0] {
        LSR_IRQ_OFF = 2'b00,
        LSR_IRQ_LEVEL = 2'b01,
        LSR_IRQ_RSV2 = 2'b10,
        LSR_IRQ_RSV3 = 2'b11
    } lsr_irq_mode_e;
    typedef enum logic [1:0] {
        LSR_TXN_REPEAT = 2'b00,
        LSR_TXN_AUTOINC = 2'b01,
        LSR_TXN_RSV = 2'b10,
        LSR_TXN_SPECIAL = 2'b11
    } lsr_txn_e;
    typedef logic [7:0] lsr_byte_t;
endpackage

// file: logic/lsr_regs.sv
`timescale 1ns/1ps
`include "lsr_params.svh"
// Function
// - flag low event when value <= lower
// - flag high event when value > upper
// - lower limit from bytes 3h, 4h
// - upper limit from bytes 5h, 6h
// - limit bytes reset to zero
// - single-byte data with msb set is command
// - gain bits 1:0 select amplification
// - identification byte constant, writes ignored
// - results 16 bit at 14h-17h
// - result bytes ignore writes, reset zero
// - low read latches high byte shadow
// - shadow holds across new conversions
// - word read returns low then high
// - manual counter counts 10.9 us ticks
// - manual counter overflows past 714.3 ms
// - manual counter bytes reset zero
// - supplemental ident bit 7 fixed
// - special function 00001 clears interrupt
// - mode 00 disables, 01 level interrupt
// - persistence counts consecutive out-of-window
// - manual start/stop when timing zero
module lsr_regs
    import lsr_pkg::*;
#(
    parameter logic [3:0] PART_CODE = 4'h5, // arbitrary value
    parameter logic [3:0] REV_CODE = 4'h2, // arbitrary value
    parameter logic SUPP_ID_VALUE = 1'b0, // arbitrary value
    parameter int TICK_CYCLES = `LSR_TICK_CYCLES
) (
    input wire logic clk, // 40 MHz system clock
    input wire logic rst_b, // async power-on reset, active low
    input wire logic [4:0] reg_addr, // register pointer from decoder
    input wire logic wr_stb, // one-cycle write strobe
    input wire logic [7:0] wr_data, // write byte
    input wire logic wr_single_byte, // write is from the byte protocol
    input wire logic rd_stb, // one-cycle read strobe
    input wire logic spf_stb, // special-function command pulse
    input wire logic [4:0] spf_code, // special-function code
    input wire logic [7:0] timing_setting, // integration time setting
    input wire logic [1:0] irq_mode_select, // interrupt mode field
    input wire logic [3:0] persist_setting, // persistence field
    input wire logic conv_done, // conversion done pulse
    input wire logic [15:0] ch0_result, // broadband result
    input wire logic [15:0] ch1_result, // infrared result
    output logic [7:0] rd_data, // read byte, valid after rd_stb
    output logic rd_valid, // pulse with rd_data
    output logic cmd_reload, // pulse: byte write taken as command
    output logic [7:0] cmd_byte, // the command byte on reload
    output logic [1:0] gain_select, // analog gain
    output logic [15:0] low_limit, // lower threshold
    output logic [15:0] high_limit, // upper threshold
    output logic window_low, // last ch0 at or below lower
    output logic window_high, // last ch0 above upper
    output logic irq_req, // level interrupt request, active high
    output logic manual_active, // manual integration running
    output logic manual_overflow // manual counter wrapped
);
    typedef struct packed {
        logic [7:0] ll_lo;
        logic [7:0] ll_hi;
        logic [7:0] hl_lo;
        logic [7:0] hl_hi;
        logic [7:0] analog;
        logic [7:0] supp;
        logic [15:0] ch0;
        logic [15:0] ch1;
        logic [7:0] shadow0;
        logic [7:0] shadow1;
        logic [15:0] dur;
        logic manual;
        logic ovf;
        logic low_ev;
        logic high_ev;
        logic [3:0] pers_cnt;
        logic irq;
        logic [7:0] rd_data;
        logic rd_valid;
        logic cmd_reload;
        logic [7:0] cmd_byte;
    } lsr_regs_s;
    lsr_regs_s st_r;
    lsr_regs_s st_nxt;
    logic tick;
    logic [15:0] lo_lim;
    logic [15:0] hi_lim;
    logic out_win;
    logic lo_hit;
    logic hi_hit;
    lsr_tick_div #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .run(st_r.manual),
        .tick(tick)
    );
    assign lo_lim = {st_r.ll_hi, st_r.ll_lo};
    assign hi_lim = {st_r.hl_hi, st_r.hl_lo};
    assign lo_hit = (ch0_result <= lo_lim);
    assign hi_hit = (ch0_result > hi_lim);
    assign out_win = lo_hit | hi_hit;
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        st_nxt.cmd_reload = 1'b0;
        // register writes, byte granularity at the decoder pointer
        if (wr_stb) begin
            if (wr_single_byte && wr_data[7]) begin
                st_nxt.cmd_reload = 1'b1;
                st_nxt.cmd_byte = wr_data;
            end else begin
                unique case (reg_addr)
                    `LSR_OFS_LOW_LIMIT_LO: st_nxt.ll_lo = wr_data;
                    `LSR_OFS_LOW_LIMIT_HI: st_nxt.ll_hi = wr_data;
                    `LSR_OFS_HIGH_LIMIT_LO: st_nxt.hl_lo = wr_data;
                    `LSR_OFS_HIGH_LIMIT_HI: st_nxt.hl_hi = wr_data;
                    `LSR_OFS_ANALOG_GAIN: st_nxt.analog = wr_data;
                    // only reserved bits are storable here
                    `LSR_OFS_SUPP_IDENT: st_nxt.supp = wr_data;
                    // ident, results and timer ignore writes
                    default: st_nxt.analog = st_nxt.analog;
                endcase
            end
        end
        // reads; shadow latch on low-byte reads
        if (rd_stb) begin
            st_nxt.rd_valid = 1'b1;
            unique case (reg_addr)
                `LSR_OFS_LOW_LIMIT_LO: st_nxt.rd_data = st_r.ll_lo;
                `LSR_OFS_LOW_LIMIT_HI: st_nxt.rd_data = st_r.ll_hi;
                `LSR_OFS_HIGH_LIMIT_LO: st_nxt.rd_data = st_r.hl_lo;
                `LSR_OFS_HIGH_LIMIT_HI: st_nxt.rd_data = st_r.hl_hi;
                `LSR_OFS_ANALOG_GAIN: st_nxt.rd_data = st_r.analog;
                `LSR_OFS_PART_REV_ID:
                    st_nxt.rd_data = {PART_CODE, REV_CODE};
                `LSR_OFS_BROADBAND_LO: begin
                    st_nxt.rd_data = st_r.ch0[7:0];
                    st_nxt.shadow0 = st_r.ch0[15:8];
                end
                `LSR_OFS_BROADBAND_HI: st_nxt.rd_data = st_r.shadow0;
                `LSR_OFS_INFRARED_LO: begin
                    st_nxt.rd_data = st_r.ch1[7:0];
                    st_nxt.shadow1 = st_r.ch1[15:8];
                end
                `LSR_OFS_INFRARED_HI: st_nxt.rd_data = st_r.shadow1;
                `LSR_OFS_DURATION_LO: st_nxt.rd_data = st_r.dur[7:0];
                `LSR_OFS_DURATION_HI: st_nxt.rd_data = st_r.dur[15:8];
                `LSR_OFS_SUPP_IDENT:
                    st_nxt.rd_data = {SUPP_ID_VALUE, st_r.supp[6:0]};
                default: st_nxt.rd_data = `LSR_RESET_BYTE;
            endcase
        end
        // results load; shadows untouched so a pair stays coherent
        if (conv_done) begin
            st_nxt.ch0 = ch0_result;
            st_nxt.ch1 = ch1_result;
            st_nxt.low_ev = lo_hit;
            st_nxt.high_ev = hi_hit;
            if (!out_win) begin
                st_nxt.pers_cnt = 4'h0;
            end else if (st_r.pers_cnt != 4'hF) begin
                st_nxt.pers_cnt = st_r.pers_cnt + 4'h1;
            end
            // 0 fires on every conversion, 1 on any, N needs N in a row
            if (irq_mode_select == LSR_IRQ_LEVEL) begin
                if (persist_setting == 4'h0) begin
                    st_nxt.irq = 1'b1;
                // five bits so a saturated count of 15 cannot wrap to 0
                end else if (out_win && ({1'b0, st_r.pers_cnt} + 5'h01 >=
                                         {1'b0, persist_setting})) begin
                    st_nxt.irq = 1'b1;
                end
            end
        end
        // special functions; a clear loses to a same-cycle new event
        if (spf_stb) begin
            unique case (spf_code)
                `LSR_SPF_IRQ_CLEAR: begin
                    if (!(conv_done && st_nxt.irq && !st_r.irq)) begin
                        st_nxt.irq = 1'b0;
                    end
                    st_nxt.pers_cnt = 4'h0;
                end
                `LSR_SPF_START_MANUAL: begin
                    if (timing_setting == 8'h00) begin
                        st_nxt.manual = 1'b1;
                        st_nxt.dur = 16'h0000;
                        st_nxt.ovf = 1'b0;
                    end
                end
                `LSR_SPF_STOP_MANUAL: begin
                    if (timing_setting == 8'h00) begin
                        st_nxt.manual = 1'b0;
                    end
                end
                default: st_nxt.manual = st_nxt.manual;
            endcase
        end
        // counter wraps past 714.3 ms; overflow flag sticks until restart
        if (st_r.manual && tick) begin
            st_nxt.dur = st_r.dur + 16'h0001;
            if (st_r.dur == 16'hFFFF) begin
                st_nxt.ovf = 1'b1;
            end
        end
        if (irq_mode_select == LSR_IRQ_OFF) begin
            st_nxt.irq = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign rd_data = st_r.rd_data;
    assign rd_valid = st_r.rd_valid;
    assign cmd_reload = st_r.cmd_reload;
    assign cmd_byte = st_r.cmd_byte;
    assign gain_select = st_r.analog[`LSR_GAIN_MSB:`LSR_GAIN_LSB];
    assign low_limit = {st_r.ll_hi, st_r.ll_lo};
    assign high_limit = {st_r.hl_hi, st_r.hl_lo};
    assign window_low = st_r.low_ev;
    assign window_high = st_r.high_ev;
    assign irq_req = st_r.irq;
    assign manual_active = st_r.manual;
    assign manual_overflow = st_r.ovf;
endmodule

// file: logic/lsr_tick_div.sv
`timescale 1ns/1ps
`include "lsr_params.svh"
module lsr_tick_div
    import lsr_pkg::*;
#(
    parameter int CYCLES = `LSR_TICK_CYCLES
) (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic run, // count while high, restart on low
    output logic tick // one-cycle pulse per period
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } lsr_div_s;
    lsr_div_s st_r;
    lsr_div_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run) begin
            st_nxt.cnt = 16'h0000;
        end else if (st_r.cnt == 16'(CYCLES - 1)) begin
            st_nxt.cnt = 16'h0000;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign tick = st_r.tick;
endmodule

// file: tb/light_sensor_threshold_data_regs_test.sv
`timescale 1ns/1ps
module light_sensor_threshold_data_regs_test;
    logic clk, rst_b, wr_stb, wr_single_byte, rd_stb, spf_stb, conv_done;
    logic rd_valid, cmd_reload, window_low, window_high, irq_req;
    logic manual_active, manual_overflow;
    logic [1:0] irq_mode_select, gain_select;
    logic [3:0] persist_setting;
    logic [4:0] reg_addr, spf_code;
    logic [7:0] wr_data, timing_setting, rd_data, cmd_byte, got;
    logic [15:0] ch0_result, ch1_result, low_limit, high_limit, l, h, v;
    logic [4:0] ofs [11] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
        5'h14, 5'h15, 5'h16, 5'h18, 5'h19};
    int fail_count = 0;
    int cmp_count = 0;
    lsr_regs #(.TICK_CYCLES(1)) i_dut (.clk, .rst_b, .reg_addr, .wr_stb,
        .wr_data, .wr_single_byte, .rd_stb, .spf_stb, .spf_code,
        .timing_setting, .irq_mode_select, .persist_setting, .conv_done,
        .ch0_result, .ch1_result, .rd_data, .rd_valid, .cmd_reload,
        .cmd_byte, .gain_select, .low_limit, .high_limit, .window_low,
        .window_high, .irq_req, .manual_active, .manual_overflow);
    lsr_host i_host (.clk, .reg_addr, .wr_stb, .wr_data, .wr_single_byte,
        .rd_stb, .spf_stb, .spf_code, .rd_data);
    function automatic logic [15:0] win(input logic [15:0] x);
        return {13'h0000, x <= l, x > h, (x <= l) || (x > h)};
    endfunction
    task automatic chk(input logic [15:0] e, input logic [15:0] a);
        cmp_count++;
        if (a !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic rd(input logic [4:0] a);
        i_host.acc(2'd1, a, 8'h00, 1'b0, got);
    endtask
    task automatic sf(input logic [4:0] c);
        i_host.acc(2'd2, c, 8'h00, 1'b0, got);
    endtask
    task automatic conv(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk);
        {ch0_result, ch1_result, conv_done} <= {a, b, 1'b1};
        @(posedge clk);
        {ch0_result, ch1_result, conv_done} <= {~a, ~b, 1'b0};
        @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("compares %0d fails %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #2250000;
        fail_count++;
        finish_test();
    end
    initial begin
        {rst_b, conv_done, ch0_result, ch1_result} = '0;
        {timing_setting, irq_mode_select, persist_setting} = 14'h0111;
        void'($urandom(9529));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ofs[i]) begin
            rd(ofs[i]);
            chk(16'h0000, got);
        end
        repeat (2) begin
            rd(5'h12);
            chk(16'h0052, got);
            i_host.acc(2'd0, 5'h12, 8'hFF, 1'b0, got);
        end
        rd(5'h1E);
        chk(16'h0000, got[7]);
        // corners on both limits first, then random values
        for (int k = 0; k < 12; k++) begin
            l = 16'($urandom);
            h = 16'($urandom);
            i_host.wr_word(5'h03, l);
            i_host.wr_word(5'h05, h);
            chk(l, low_limit);
            chk(h, high_limit);
            v = k[1] ? l + 16'(k[0]) : h + 16'(k[0]);
            if (k > 7) v = 16'($urandom);
            conv(v, ~v);
            chk(win(v), {window_low, window_high, irq_req});
            sf(5'h01);
            chk(16'h0000, irq_req);
        end
        i_host.wr_word(5'h03, 16'h0100);
        i_host.wr_word(5'h05, 16'h8000);
        @(posedge clk);
        persist_setting <= 4'h3;
        for (int k = 0; k < 6; k++) begin
            conv(k == 2 ? 16'h0200 : 16'hF000, 16'h0000);
            chk(k == 5, irq_req);
        end
        @(posedge clk);
        irq_mode_select <= 2'b00;
        conv(16'hF000, 16'h0000);
        chk(16'h0000, irq_req);
        @(posedge clk);
        {irq_mode_select, persist_setting} <= 6'h10;
        conv(16'h0200, 16'h0000);
        chk(16'h0001, irq_req);
        i_host.acc(2'd0, 5'h03, 8'h93, 1'b1, got);
        chk(16'h0093, cmd_byte);
        rd(5'h03);
        chk(16'h0000, got);
        i_host.acc(2'd0, 5'h03, 8'h22, 1'b1, got);
        rd(5'h03);
        chk(16'h0022, got);
        for (int g = 0; g < 4; g++) begin
            i_host.acc(2'd0, 5'h07, 8'(g), 1'b0, got);
            chk(g, gain_select);
        end
        conv(16'hA1B2, 16'hC3D4);
        rd(5'h14);
        chk(16'h00B2, got);
        conv(16'h5566, 16'h7788);
        rd(5'h15);
        chk(16'h00A1, got);
        i_host.acc(2'd0, 5'h16, 8'hFF, 1'b0, got);
        rd(5'h16);
        v[7:0] = got;
        rd(5'h17);
        chk(16'h7788, {got, v[7:0]});
        sf(5'h03);
        chk(16'h0000, manual_active);
        @(posedge clk);
        timing_setting <= 8'h00;
        sf(5'h03);
        repeat (38) @(posedge clk);
        sf(5'h02);
        rd(5'h18);
        v[7:0] = got;
        rd(5'h19);
        chk(16'h0001, {got, v[7:0]} inside {[16'd38:16'd46]});
        sf(5'h03);
        repeat (65540) @(posedge clk);
        chk(16'h0001, manual_overflow);
        finish_test();
    end
endmodule
bind lsr_regs lsr_regs_checker i_chk (.clk, .rst_b, .reg_addr, .wr_stb,
    .wr_data, .wr_single_byte, .rd_stb, .spf_stb, .spf_code,
    .irq_mode_select, .conv_done, .ch0_result, .rd_valid, .cmd_reload,
    .cmd_byte, .gain_select, .low_limit, .high_limit, .window_low,
    .window_high, .irq_req);

// file: tb/lsr_host.sv
`timescale 1ns/1ps
module lsr_host (
    input wire logic clk, // clock
    output logic [4:0] reg_addr, // pointer
    output logic wr_stb, // write strobe
    output logic [7:0] wr_data, // write byte
    output logic wr_single_byte, // byte protocol
    output logic rd_stb, // read strobe
    output logic spf_stb, // function strobe
    output logic [4:0] spf_code, // function code
    input wire logic [7:0] rd_data // read byte
);
    initial begin
        {reg_addr, wr_data, wr_single_byte, spf_code} = '0;
        {spf_stb, rd_stb, wr_stb} = 3'b000;
    end
    // kind 0 write, 1 read, 2 function; the supplemental ident is never
    // written, since that byte can upset the sensor
    task automatic acc(input logic [1:0] k, input logic [4:0] a,
        input logic [7:0] d, input logic sb, output logic [7:0] q);
        @(posedge clk);
        {reg_addr, spf_code, wr_data, wr_single_byte} <= {a, a, d, sb};
        {spf_stb, rd_stb, wr_stb} <= 3'b001 << k;
        @(posedge clk);
        {spf_stb, rd_stb, wr_stb} <= 3'b000;
        wr_data <= ~d; // released bus does not keep the byte
        @(posedge clk);
        #1 q = rd_data;
    endtask
    // a limit word goes out as a low/high byte pair, low byte first
    task automatic wr_word(input logic [4:0] a, input logic [15:0] w);
        logic [7:0] q;
        acc(2'd0, a, w[7:0], 1'b0, q);
        acc(2'd0, a + 5'h01, w[15:8], 1'b0, q);
    endtask
endmodule

// file: tb/lsr_regs_checker.sv
`timescale 1ns/1ps
module lsr_regs_checker (
    input wire logic clk, // clock
    input wire logic rst_b, // reset
    input wire logic [4:0] reg_addr, // pointer
    input wire logic wr_stb, // write
    input wire logic [7:0] wr_data, // byte
    input wire logic wr_single_byte, // byte mode
    input wire logic rd_stb, // read
    input wire logic spf_stb, // function
    input wire logic [4:0] spf_code, // code
    input wire logic [1:0] irq_mode_select, // mode
    input wire logic conv_done, // done
    input wire logic [15:0] ch0_result, // ch0
    input wire logic rd_valid, // answer
    input wire logic cmd_reload, // command
    input wire logic [7:0] cmd_byte, // command byte
    input wire logic [1:0] gain_select, // gain
    input wire logic [15:0] low_limit, // lower
    input wire logic [15:0] high_limit, // upper
    input wire logic window_low, // low event
    input wire logic window_high, // high event
    input wire logic irq_req // interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic cmd_w;
    logic st_w;
    // a byte-mode write with the top bit set is a command, not data
    assign cmd_w = wr_stb && wr_single_byte && wr_data[7];
    assign st_w = wr_stb && !cmd_w;
    a_read_answer: assert property (rd_stb |=> rd_valid)
        else $error("read unanswered");
    a_cmd_taken: assert property (cmd_w |=> cmd_reload
        && cmd_byte == $past(wr_data)) else $error("command lost");
    a_low_store: assert property (st_w && reg_addr == 5'h03 |=>
        low_limit[7:0] == $past(wr_data)) else $error("low byte");
    a_gain_store: assert property (st_w && reg_addr == 5'h07 |=>
        gain_select == 2'($past(wr_data))) else $error("gain");
    a_low_event: assert property (conv_done |=> window_low ==
        ($past(ch0_result) <= $past(low_limit))) else $error("low event");
    a_high_event: assert property (conv_done |=> window_high ==
        ($past(ch0_result) > $past(high_limit))) else $error("high event");
    a_irq_off: assert property (irq_mode_select == 2'b00 |=> !irq_req)
        else $error("irq while off");
    a_irq_clear: assert property (spf_stb && spf_code == 5'h01
        && !conv_done |=> !irq_req) else $error("irq not cleared");
    c_cmd: cover property (cmd_reload);
    c_irq: cover property ($rose(irq_req));
    c_high: cover property (window_high);
endmodule
